//--- adccal_ctrl.sv
// calibration sequencing, sleep control, range alarm and clock config registers
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - alarm high while either result clipped
// - alarm meaningless during calibration; host ignores
// - alarm disabled at reset, bit14 clear enables
// - termination select bit: 100 or 150 ohm
// - aperture delay from sixteen-bit value register
// - aperture delay applied only when enabled
// - calibrate after power-up and on request
// - calibration active high for whole calibration
// - power-on calibration after fixed delay count
// - request pin high at power-up skips calibration
// - calibration starts 80 cycles after pin high
// - data outputs released while sleep pin high
// - sleep waits for running calibration to finish
// - sleep at power-up postpones calibration
// - requests ignored entirely while asleep
module adccal_ctrl #(
	parameter int PWRUP_CYC = adccal_pkg::POWERON_DLY_CYC,
	parameter int CALIB_CYC = adccal_pkg::CAL_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// control pins
	input wire logic cal_req_i,
	input wire logic sleep_pin_i,
	// converter results, accurate unclipped value, two converters
	input wire logic signed [9:0] conv_a_i,
	input wire logic signed [9:0] conv_b_i,
	// register write and read ports
	input wire adccal_pkg::adccal_regwr_t regwr_i,
	input wire logic [7:0] rd_addr_i,
	output logic [15:0] rd_data_o,
	// indicators and controls
	output logic calib_active_o,
	output logic range_alarm_pos_o,
	output logic range_alarm_neg_o,
	output logic data_oe_n_o,
	output adccal_pkg::adccal_clkcfg_t clkcfg_o
);

	// counters are 24 bits wide; a longer count would be cut to 24 bits and finish early
	if (PWRUP_CYC < 2 || CALIB_CYC < 2 ||
		PWRUP_CYC > 2**24 || CALIB_CYC > 2**24) begin : g_bad_counts
		$error("adccal_ctrl: counts out of range");
	end

	// ==========================================================
	// pin synchronisers, change counts once stages two and three agree
	logic [2:0] cal_sync_r;
	logic [2:0] slp_sync_r;
	logic cal_lvl_r;
	logic slp_lvl_r;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cal_sync_r <= 3'h0;
			slp_sync_r <= 3'h0;
			cal_lvl_r <= 1'b0;
			slp_lvl_r <= 1'b0;
		end else begin
			cal_sync_r <= {cal_sync_r[1:0], cal_req_i};
			slp_sync_r <= {slp_sync_r[1:0], sleep_pin_i};
			if (cal_sync_r[1] == cal_sync_r[2]) begin
				cal_lvl_r <= cal_sync_r[2];
			end
			if (slp_sync_r[1] == slp_sync_r[2]) begin
				slp_lvl_r <= slp_sync_r[2];
			end
		end
	end

	// ==========================================================
	// registers
	logic [15:0] apdly_en_r;
	logic [15:0] clk_term_r;
	logic [15:0] apdly_val_r;
	logic [15:0] alarm_ctrl_r;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			apdly_en_r <= adccal_pkg::RST_APDLY_EN;
			clk_term_r <= adccal_pkg::RST_CLK_TERM;
			apdly_val_r <= adccal_pkg::RST_APDLY_VAL;
			alarm_ctrl_r <= adccal_pkg::RST_ALARM_CTRL;
		end else if (regwr_i.wr) begin
			case (regwr_i.addr)
				adccal_pkg::ADDR_APDLY_EN: apdly_en_r <= regwr_i.wdata;
				adccal_pkg::ADDR_CLK_TERM: clk_term_r <= regwr_i.wdata;
				adccal_pkg::ADDR_APDLY_VAL: apdly_val_r <= regwr_i.wdata;
				adccal_pkg::ADDR_ALARM_CTRL: alarm_ctrl_r <= regwr_i.wdata;
				default: ;
			endcase
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_data_o <= 16'h0000;
		end else begin
			case (rd_addr_i)
				adccal_pkg::ADDR_APDLY_EN: rd_data_o <= apdly_en_r;
				adccal_pkg::ADDR_CLK_TERM: rd_data_o <= clk_term_r;
				adccal_pkg::ADDR_APDLY_VAL: rd_data_o <= apdly_val_r;
				adccal_pkg::ADDR_ALARM_CTRL: rd_data_o <= alarm_ctrl_r;
				default: rd_data_o <= 16'h0000;
			endcase
		end
	end

	// delay value is zeroed when disabled: enabling alone costs sfdr, keep values small
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			clkcfg_o <= '0;
		end else begin
			clkcfg_o.apdly_en <= apdly_en_r[adccal_pkg::BIT_APDLY_EN];
			clkcfg_o.apdly_val <= apdly_en_r[adccal_pkg::BIT_APDLY_EN] ?
				apdly_val_r : 16'h0000;
			clkcfg_o.term_150 <= clk_term_r[adccal_pkg::BIT_TERM_SEL];
		end
	end

	// ==========================================================
	// request qualification: low 80, then high 80, start 80 after rise
	logic [6:0] low_cnt_r;
	logic [6:0] high_cnt_r;
	logic low_ok_r;
	logic cal_lvl_d_r;
	logic req_pulse;
	// synchroniser latency adds a few cycles on top of the 80-cycle start delay
	assign req_pulse = cal_lvl_r && low_ok_r &&
		(high_cnt_r == 7'(adccal_pkg::REQ_QUAL_CYC - 1));
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			low_cnt_r <= 7'h00;
			high_cnt_r <= 7'h00;
			low_ok_r <= 1'b0;
			cal_lvl_d_r <= 1'b0;
		end else begin
			cal_lvl_d_r <= cal_lvl_r;
			if (cal_lvl_r != cal_lvl_d_r) begin
				low_cnt_r <= 7'h00;
				high_cnt_r <= 7'h00;
				if (cal_lvl_r == 1'b0) begin
					low_ok_r <= 1'b0;
				end
			end else if (!cal_lvl_r) begin
				if (low_cnt_r != 7'(adccal_pkg::REQ_QUAL_CYC - 1)) begin
					low_cnt_r <= low_cnt_r + 7'h01;
				end else begin
					low_ok_r <= 1'b1;
				end
			end else if (low_ok_r) begin
				if (req_pulse) begin
					low_ok_r <= 1'b0;
				end else begin
					high_cnt_r <= high_cnt_r + 7'h01;
				end
			end
		end
	end

	// ==========================================================
	// sequencer
	adccal_pkg::adccal_state_t state_r;
	logic [23:0] pwr_cnt_r;
	logic [23:0] cal_cnt_r;
	logic pwr_done_r;
	logic skip_pwron_r;
	logic strap_taken_r;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_r <= adccal_pkg::ST_PWRUP;
			pwr_cnt_r <= 24'h000000;
			cal_cnt_r <= 24'h000000;
			pwr_done_r <= 1'b0;
			skip_pwron_r <= 1'b0;
			strap_taken_r <= 1'b0;
		end else begin
			case (state_r)
				adccal_pkg::ST_PWRUP: begin
					// strap caught after reset once synchronisers settle
					if (!strap_taken_r && pwr_cnt_r == 24'(adccal_pkg::STRAP_DLY_CYC)) begin
						strap_taken_r <= 1'b1;
						skip_pwron_r <= cal_lvl_r;
					end
					if (pwr_cnt_r != 24'(PWRUP_CYC - 1)) begin
						pwr_cnt_r <= pwr_cnt_r + 24'h000001;
					end else if (!slp_lvl_r) begin
						pwr_done_r <= 1'b1;
						cal_cnt_r <= 24'h000000;
						state_r <= skip_pwron_r ? adccal_pkg::ST_IDLE
							: adccal_pkg::ST_CAL;
					end
				end
				adccal_pkg::ST_IDLE: begin
					if (slp_lvl_r) begin
						state_r <= adccal_pkg::ST_SLEEP;
					end else if (req_pulse) begin
						cal_cnt_r <= 24'h000000;
						state_r <= adccal_pkg::ST_CAL;
					end
				end
				adccal_pkg::ST_CAL: begin
					// sleep is only looked at once the run is over
					if (cal_cnt_r == 24'(CALIB_CYC - 1)) begin
						state_r <= slp_lvl_r ? adccal_pkg::ST_SLEEP
							: adccal_pkg::ST_IDLE;
					end else begin
						cal_cnt_r <= cal_cnt_r + 24'h000001;
					end
				end
				adccal_pkg::ST_SLEEP: begin
					// requests are dropped here, never queued
					if (!slp_lvl_r) begin
						state_r <= adccal_pkg::ST_IDLE;
					end
				end
				default: state_r <= adccal_pkg::ST_PWRUP;
			endcase
		end
	end

	// ==========================================================
	// outputs
	logic clip_a;
	logic clip_b;
	assign clip_a = (conv_a_i < 10'sd0) || (conv_a_i > $signed({2'b00, adccal_pkg::CODE_MAX}));
	assign clip_b = (conv_b_i < 10'sd0) || (conv_b_i > $signed({2'b00, adccal_pkg::CODE_MAX}));
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			calib_active_o <= 1'b0;
			range_alarm_pos_o <= 1'b0;
			range_alarm_neg_o <= 1'b1;
			data_oe_n_o <= 1'b1;
		end else begin
			calib_active_o <= (state_r == adccal_pkg::ST_CAL);
			// value during calibration is not meaningful to the host
			range_alarm_pos_o <= !alarm_ctrl_r[adccal_pkg::BIT_ALARM_OFF] &&
				(clip_a || clip_b);
			range_alarm_neg_o <= !(!alarm_ctrl_r[adccal_pkg::BIT_ALARM_OFF] &&
				(clip_a || clip_b));
			data_oe_n_o <= slp_lvl_r || (state_r == adccal_pkg::ST_SLEEP);
		end
	end

	// ==========================================================
	// checks
	chk_alarm_pair: assert property (@(posedge mclk_i) disable iff (srst_i)
		range_alarm_pos_o != range_alarm_neg_o) else $error("alarm pair not complementary");
	chk_alarm_off: assert property (@(posedge mclk_i) disable iff (srst_i)
		alarm_ctrl_r[adccal_pkg::BIT_ALARM_OFF] |=> !range_alarm_pos_o)
		else $error("alarm while disabled");
	chk_term_sel: assert property (@(posedge mclk_i) disable iff (srst_i)
		##1 clkcfg_o.term_150 == $past(clk_term_r[adccal_pkg::BIT_TERM_SEL]))
		else $error("termination mismatch");
	chk_apdly_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
		!clkcfg_o.apdly_en |-> clkcfg_o.apdly_val == 16'h0000) else $error("delay while off");
	chk_cal_flag: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_r == adccal_pkg::ST_CAL) |=> calib_active_o) else $error("active flag low");
	chk_req_start: assert property (@(posedge mclk_i) disable iff (srst_i)
		(req_pulse && state_r == adccal_pkg::ST_IDLE && !slp_lvl_r)
		|=> state_r == adccal_pkg::ST_CAL ##1 calib_active_o) else $error("request lost");
	chk_sleep_wait: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_r == adccal_pkg::ST_CAL && cal_cnt_r != 24'(CALIB_CYC - 1))
		|=> state_r == adccal_pkg::ST_CAL) else $error("calibration cut short");
	chk_sleep_ign: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_r == adccal_pkg::ST_SLEEP) |=> state_r != adccal_pkg::ST_CAL)
		else $error("cal in sleep");
	chk_pwrup_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_r == adccal_pkg::ST_PWRUP && slp_lvl_r) |=> state_r == adccal_pkg::ST_PWRUP)
		else $error("cal during sleep strap");
	chk_data_hiz: assert property (@(posedge mclk_i) disable iff (srst_i)
		slp_lvl_r |=> data_oe_n_o) else $error("data driven in sleep");

	// ==========================================================
	// power-up, strap, qualification and clip alarm checks
	chk_pwrup_wait: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_r == adccal_pkg::ST_PWRUP && pwr_cnt_r != 24'(PWRUP_CYC - 1))
		|=> state_r == adccal_pkg::ST_PWRUP) else $error("power-on delay cut short");
	chk_pwrup_once: assert property (@(posedge mclk_i) disable iff (srst_i)
		pwr_done_r |-> state_r != adccal_pkg::ST_PWRUP)
		else $error("power-up delay entered twice");
	chk_strap_skip: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_r == adccal_pkg::ST_PWRUP && skip_pwron_r) |=> state_r != adccal_pkg::ST_CAL)
		else $error("power-on cal despite strap");
	chk_qual_restart: assert property (@(posedge mclk_i) disable iff (srst_i)
		(cal_lvl_r != cal_lvl_d_r) |=> (low_cnt_r == 7'h00 && high_cnt_r == 7'h00))
		else $error("qualification not restarted");
	chk_alarm_clip: assert property (@(posedge mclk_i) disable iff (srst_i)
		(!alarm_ctrl_r[adccal_pkg::BIT_ALARM_OFF] &&
		(conv_a_i[9:8] != 2'b00 || conv_b_i[9:8] != 2'b00)) |=> range_alarm_pos_o)
		else $error("clip not flagged");

endmodule : adccal_ctrl

`default_nettype wire

//--- adccal_pkg.sv
// package for the adc calibration and power-down control block
`default_nettype none
package adccal_pkg;

	// ==========================================================
	// register map (16-bit registers, printed offsets)
	localparam logic [7:0] ADDR_APDLY_EN = 8'h01;
	localparam logic [7:0] ADDR_CLK_TERM = 8'h02;
	localparam logic [7:0] ADDR_APDLY_VAL = 8'h0c;
	localparam logic [7:0] ADDR_ALARM_CTRL = 8'h14;
	localparam int BIT_APDLY_EN = 0;
	localparam int BIT_TERM_SEL = 14;
	localparam int BIT_ALARM_OFF = 14;
	localparam logic [15:0] RST_APDLY_EN = 16'h0000;
	localparam logic [15:0] RST_CLK_TERM = 16'h0000;
	localparam logic [15:0] RST_APDLY_VAL = 16'h0000;
	localparam logic [15:0] RST_ALARM_CTRL = 16'h4000;

	// ==========================================================
	// codes and timing
	localparam logic [7:0] CODE_MIN = 8'h00;
	localparam logic [7:0] CODE_MAX = 8'hff;
	localparam int POWERON_DLY_CYC = 8388608;
	localparam int REQ_QUAL_CYC = 80;
	// power-up strap is taken once the pin synchroniser has settled
	localparam int STRAP_DLY_CYC = 4;
	// calibration time in ns as printed, cycles at 200 MHz (5 ns)
	localparam int CAL_TIME_NS = 1160000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CAL_CYC = CAL_TIME_NS / CLK_PERIOD_NS;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_PWRUP = 3'b000,
		ST_IDLE = 3'b001,
		ST_CAL = 3'b010,
		ST_SLEEP = 3'b011
	} adccal_state_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} adccal_regwr_t;

	typedef struct packed {
		logic apdly_en;
		logic [15:0] apdly_val;
		logic term_150;
	} adccal_clkcfg_t;

endpackage : adccal_pkg
`default_nettype wire

//--- adccal_host.sv
// host model that drives the calibration request and sleep pins
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// host pin driver
module adccal_host (
	// clock
	input wire logic mclk_i,
	// pins toward the device
	output logic cal_req_o,
	output logic sleep_o
);
	initial begin
		cal_req_o = 1'b0;
		sleep_o = 1'b0;
	end

	task automatic pins(input logic c, input logic s);
		@(posedge mclk_i);
		cal_req_o <= c;
		sleep_o <= s;
	endtask : pins

	// low phase, then high; left high so the high phase is never cut short
	task automatic req(input int lo);
		pins(1'b0, sleep_o);
		repeat (lo) @(posedge mclk_i);
		cal_req_o <= 1'b1;
	endtask : req
endmodule : adccal_host
`default_nettype wire

//--- tb.sv
// testbench for the calibration and sleep control block
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// bench
module tb;
	logic mclk_i;
	logic srst_i;
	logic cal_req;
	logic sleep;
	// no range or offset registers here; both converters share one clip bound
	logic signed [9:0] conv_a_i;
	logic signed [9:0] conv_b_i;
	adccal_pkg::adccal_regwr_t regwr_i;
	logic [7:0] rd_addr_i;
	logic [15:0] rd_data_o;
	logic calib_active_o;
	logic range_alarm_pos_o;
	logic range_alarm_neg_o;
	logic data_oe_n_o;
	adccal_pkg::adccal_clkcfg_t clkcfg_o;
	int fails = 0;
	int check_count = 0;
	int n;

	always #2.5 mclk_i = ~mclk_i;

	adccal_host host (.mclk_i(mclk_i), .cal_req_o(cal_req), .sleep_o(sleep));

	// short counts keep the run small
	adccal_ctrl #(.PWRUP_CYC(200), .CALIB_CYC(50)) uut (
		.mclk_i(mclk_i), .srst_i(srst_i), .cal_req_i(cal_req), .sleep_pin_i(sleep),
		.conv_a_i(conv_a_i), .conv_b_i(conv_b_i), .regwr_i(regwr_i),
		.rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .calib_active_o(calib_active_o),
		.range_alarm_pos_o(range_alarm_pos_o), .range_alarm_neg_o(range_alarm_neg_o),
		.data_oe_n_o(data_oe_n_o), .clkcfg_o(clkcfg_o));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask : tick

	task automatic do_rst();
		@(posedge mclk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
	endtask : do_rst

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		regwr_i <= '{1'b1, a, d};
		@(posedge mclk_i);
		regwr_i <= '0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk_i);
		rd_addr_i <= a;
		tick(2);
		chk(rd_data_o, e);
	endtask : rd_chk

	// a missing start when one is due ends the run
	task automatic wait_act(input int lim, input bit must, output int cnt);
		cnt = 0;
		while (calib_active_o !== 1'b1 && cnt < lim) begin
			tick(1);
			cnt++;
		end
		if (must && cnt >= lim) begin
			fails++;
			$display("mismatch at %0t: calibration did not start", $time);
			give_verdict();
		end
	endtask : wait_act

	task automatic cal_len(input int e);
		int c;
		c = 0;
		while (calib_active_o === 1'b1 && c < 100) begin
			tick(1);
			c++;
		end
		chk(16'(c), 16'(e));
	endtask : cal_len

	task automatic alarm(input logic signed [9:0] a, input logic signed [9:0] b, input logic p);
		@(posedge mclk_i);
		conv_a_i <= a;
		conv_b_i <= b;
		tick(2);
		chk({14'h0, range_alarm_pos_o, range_alarm_neg_o}, {14'h0, p, ~p});
	endtask : alarm

	task automatic t_poweron();
		do_rst();
		wait_act(300, 1'b1, n);
		chk(16'(n >= 200 && n <= 203), 16'h0001);
		cal_len(50);
		$display("power-on calibration test done");
	endtask : t_poweron

	// alarm is never judged while calibrating, its value is meaningless then
	task automatic t_regs();
		rd_chk(8'h01, 16'h0000);
		rd_chk(8'h02, 16'h0000);
		rd_chk(8'h0c, 16'h0000);
		rd_chk(8'h14, 16'h4000);
		rd_chk(8'h20, 16'h0000);
		alarm(10'sd300, 10'sd5, 1'b0);
		wr(8'h14, 16'h0000);
		alarm(10'sd256, 10'sd5, 1'b1);
		alarm(10'sd255, 10'sd0, 1'b0);
		alarm(10'sd7, -10'sd1, 1'b1);
		wr(8'h0c, 16'h1234);
		tick(3);
		chk(clkcfg_o.apdly_val, 16'h0000);
		wr(8'h01, 16'h0001);
		tick(3);
		chk({clkcfg_o.apdly_en, clkcfg_o.apdly_val[14:0]}, 16'h9234);
		wr(8'h02, 16'h4000);
		tick(3);
		chk(16'(clkcfg_o.term_150), 16'h0001);
		rd_chk(8'h02, 16'h4000);
		$display("register and alarm test done");
	endtask : t_regs

	task automatic t_cmd();
		host.req(100);
		wait_act(200, 1'b1, n);
		chk(16'(n >= 80 && n <= 86), 16'h0001);
		cal_len(50);
		host.req(40);
		wait_act(200, 1'b0, n);
		chk(16'(n), 16'd200);
		$display("on-command calibration test done");
	endtask : t_cmd

	task automatic t_sleep();
		host.req(100);
		wait_act(200, 1'b1, n);
		host.pins(1'b1, 1'b1);
		cal_len(49);
		tick(3);
		chk(16'(data_oe_n_o), 16'h0001);
		host.req(100);
		wait_act(200, 1'b0, n);
		chk(16'(n), 16'd200);
		host.pins(1'b1, 1'b0);
		// data after wake is flushed by the host, never judged here
		tick(6);
		chk(16'(data_oe_n_o), 16'h0000);
		wait_act(150, 1'b0, n);
		chk(16'(n), 16'd150);
		$display("sleep test done");
	endtask : t_sleep

	task automatic t_straps();
		do_rst();
		wait_act(300, 1'b0, n);
		chk(16'(n), 16'd300);
		host.req(100);
		wait_act(200, 1'b1, n);
		cal_len(50);
		host.pins(1'b0, 1'b1);
		do_rst();
		wait_act(300, 1'b0, n);
		chk(16'(n), 16'd300);
		host.pins(1'b0, 1'b0);
		wait_act(300, 1'b1, n);
		cal_len(50);
		$display("power-up strap test done");
	endtask : t_straps

	initial begin
		mclk_i = 1'b0;
		srst_i = 1'b1;
		conv_a_i = 10'sh080;
		conv_b_i = 10'sh080;
		regwr_i = '0;
		rd_addr_i = 8'h00;
		t_poweron();
		t_regs();
		t_cmd();
		t_sleep();
		t_straps();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
